// >>> shared/qrpe_defs.vh
// Purpose: constants for the quad read dummy setting and page erase sequencer
// Assumes: clk at 10 MHz, serial link sampled by clk
// Notes: field positions refer to the status bytes held inside the device
`ifndef QRPE_DEFS_VH
`define QRPE_DEFS_VH
`define QRPE_OP_PAGE_ERASE_A 8'h81
`define QRPE_OP_PAGE_ERASE_B 8'hdb
`define QRPE_OP_WRITE_ENABLE 8'h06
`define QRPE_OP_QUAD_READ 8'heb
`define QRPE_OP_QUAD_READ_DWA 8'he7
`define QRPE_OP_WRAP_SET 8'h77
`define QRPE_SR5_DC_HI 6
`define QRPE_SR5_DC_LO 4
`define QRPE_SR5_DWA_BIT 0
`define QRPE_SR1_BUSY_BIT 0
`define QRPE_SR1_WEL_BIT 1
`define QRPE_SR5_RESET 8'h00
`define QRPE_MODE_CLOCKS 5'h02
`define QRPE_FRAME_BITS 6'h20
`define QRPE_PAGE_MSB 19
`define QRPE_PAGE_LSB 8
`define QRPE_PE_TIME_US 20
`define QRPE_CLK_MHZ 10
`define QRPE_PE_CYCLES (`QRPE_PE_TIME_US * `QRPE_CLK_MHZ)
`endif

// >>> rtl/qrpe_sequencer.v
// Purpose: dummy-clock selection for quad reads and single page erase command handling
// Assumes: link clock and chip select come from outside and are synchronised to clk
// Notes: the array itself sits outside; this block issues a page erase request to it
//
// Overview of operation
// - dummy count taken from status byte five bits 6 to 4
// - codes 000 to 100 give 2, 4, 6, 8, 10 dummy clocks
// - dummy count includes the two clocks of the eight mode bits
// - quad read EBh honours the doubleword align select at bit 0
// - quad read E7h ignores the doubleword align select
// - wrap mode set by 77h changes the frequency limits only
// - opcodes 81h and DBh both erase one page
// - erase command and address arrive on the single serial input line
// - opcode is eight clocks, most significant bit first
// - address is 24 clocks starting with bit 23
// - page index is address bits 19 to 8, others ignored
// - erase starts on chip select rising, page ends all ones
// - erase is self timed and ends within the maximum erase time
// - busy flag is set throughout the erase
// - busy shows as bit 0 of status byte one
// - write enable latch cleared before the erase ends
// - chip select rising off a byte boundary abandons the erase
// - incomplete address aborts the erase
`timescale 1ns/1ps
`include "qrpe_defs.vh"
module qrpe_sequencer #(
   parameter PE_CYCLES = `QRPE_PE_CYCLES
) (
   input wire clk,
   input wire arst_n,
   input wire sck,
   input wire cs_n,
   input wire si,
   input wire [7:0] sr5_cfg,
   input wire wrap_mode,
   output reg [7:0] status1,
   output reg [4:0] quad_read_dummy,
   output reg [4:0] quad_read_dwa_dummy,
   output reg quad_read_aligned,
   output reg erase_start,
   output reg [11:0] page_index,
   output reg erase_fill
);
   // ------------------------------------------------------------
   // dummy clock decode
   // ------------------------------------------------------------
   function [4:0] qrpe_dummy;
      input [2:0] code;
      begin
         case (code)
            3'h0: qrpe_dummy = 5'h02;
            3'h1: qrpe_dummy = 5'h04;
            3'h2: qrpe_dummy = 5'h06;
            3'h3: qrpe_dummy = 5'h08;
            3'h4: qrpe_dummy = 5'h0a;
            default: qrpe_dummy = 5'h0a;
         endcase
      end
   endfunction

   // wrap mode only shifts the host-side frequency limits, dummy count is the same
   wire unused_wrap = wrap_mode;
   wire [4:0] dummy_nxt = qrpe_dummy(sr5_cfg[`QRPE_SR5_DC_HI:`QRPE_SR5_DC_LO]);

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // code 000 after reset, which is the two mode clocks alone
         quad_read_dummy <= `QRPE_MODE_CLOCKS;
         quad_read_dwa_dummy <= `QRPE_MODE_CLOCKS;
         quad_read_aligned <= 1'b0;
      end else begin
         // mode bits occupy the first two of these clocks
         quad_read_dummy <= dummy_nxt;
         quad_read_dwa_dummy <= dummy_nxt;
         quad_read_aligned <= sr5_cfg[`QRPE_SR5_DWA_BIT];
      end
   end

   // ------------------------------------------------------------
   // link synchronisers
   // ------------------------------------------------------------
   reg [1:0] sck_s_r;
   reg [1:0] cs_s_r;
   reg [1:0] si_s_r;
   reg sck_d_r;
   reg cs_d_r;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_s_r <= 2'h0;
         cs_s_r <= 2'h3;
         si_s_r <= 2'h0;
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else begin
         sck_s_r <= {sck_s_r[0], sck};
         cs_s_r <= {cs_s_r[0], cs_n};
         si_s_r <= {si_s_r[0], si};
         sck_d_r <= sck_s_r[1];
         cs_d_r <= cs_s_r[1];
      end
   end
   wire cs_act = ~cs_s_r[1];
   wire sck_rise = sck_s_r[1] & ~sck_d_r;
   wire cs_rise = cs_s_r[1] & ~cs_d_r;

   // ------------------------------------------------------------
   // frame decode
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'b01;
   localparam ST_ERASE = 2'b10;
   reg [1:0] state_r;
   reg [31:0] shift_r;
   reg [5:0] nbits_r;
   reg bad_r;
   reg [31:0] timer_r;

   wire [7:0] op = shift_r[31:24];
   wire is_pe = (op == `QRPE_OP_PAGE_ERASE_A) || (op == `QRPE_OP_PAGE_ERASE_B);
   // exactly 32 clocks: a short address or a cut byte leaves framed low
   wire framed = (nbits_r == `QRPE_FRAME_BITS) && !bad_r;
   wire is_wren = (nbits_r == 6'h08) && !bad_r && (shift_r[7:0] == `QRPE_OP_WRITE_ENABLE);
   wire write_enable_latch = status1[`QRPE_SR1_WEL_BIT];
   wire idle = (state_r == ST_IDLE);
   // frames that end while busy are shifted but never acted on
   wire wren_go = cs_rise && is_wren && idle;
   wire pe_go = cs_rise && framed && is_pe && write_enable_latch && idle;
   wire erase_last = (state_r == ST_ERASE) && (timer_r == 32'h1);
   wire erase_done = (state_r == ST_ERASE) && (timer_r == 32'h0);

   // ------------------------------------------------------------
   // command shifter
   // ------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_r <= 32'h0;
         nbits_r <= 6'h0;
         bad_r <= 1'b0;
      end else begin
         if (cs_act && sck_rise) begin
            // serial input on one line, msb first
            shift_r <= {shift_r[30:0], si_s_r[1]};
            if (nbits_r == `QRPE_FRAME_BITS)
               bad_r <= 1'b1;
            else
               nbits_r <= nbits_r + 6'h01;
         end
         // counters restart for the next frame once select is released
         if (cs_rise) begin
            nbits_r <= 6'h0;
            bad_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // erase sequencing
   // ------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_IDLE;
         timer_r <= 32'h0;
         erase_start <= 1'b0;
         erase_fill <= 1'b1;
         page_index <= 12'h000;
      end else begin
         erase_start <= 1'b0;
         erase_fill <= 1'b1;
         case (state_r)
            ST_IDLE: begin
               if (pe_go) begin
                  page_index <= shift_r[`QRPE_PAGE_MSB:`QRPE_PAGE_LSB];
                  erase_start <= 1'b1;
                  timer_r <= PE_CYCLES - 1;
                  state_r <= ST_ERASE;
               end
            end
            ST_ERASE: begin
               // self timed, no link clocks needed
               if (erase_done)
                  state_r <= ST_IDLE;
               else
                  timer_r <= timer_r - 32'h1;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // status byte one
   // ------------------------------------------------------------
   // set and clear of each bit fall in different states, so never together
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status1 <= 8'h00;
      end else begin
         if (wren_go)
            status1[`QRPE_SR1_WEL_BIT] <= 1'b1;
         if (erase_last)
            status1[`QRPE_SR1_WEL_BIT] <= 1'b0;
         if (pe_go)
            status1[`QRPE_SR1_BUSY_BIT] <= 1'b1;
         if (erase_done)
            status1[`QRPE_SR1_BUSY_BIT] <= 1'b0;
      end
   end
endmodule

// >>> bench/qrpe_sequencer_sva.sv
// Purpose: port level checks of the quad read dummy and page erase sequencer
// Assumes: bound to the top module, one clock domain
// Notes: busy length is counted in helper logic
`timescale 1ns/1ps
module qrpe_sequencer_sva #(parameter int PE_CYCLES = 8) (
   input wire clk,
   input wire arst_n,
   input wire cs_n,
   input wire [7:0] sr5_cfg,
   input wire [7:0] status1,
   input wire [4:0] quad_read_dummy,
   input wire [4:0] quad_read_dwa_dummy,
   input wire quad_read_aligned,
   input wire erase_start,
   input wire [11:0] page_index,
   input wire erase_fill
);
   logic [15:0] busy_cnt_r;
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) busy_cnt_r <= 16'h0;
      else busy_cnt_r <= status1[0] ? busy_cnt_r + 16'h1 : 16'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence erase_begin;
      erase_start && status1[1:0] == 2'b11;
   endsequence
   chk_start_busy: assert property (erase_start |-> erase_begin)
      else $error("start without busy");
   chk_start_pulse: assert property (erase_begin |=> !erase_start)
      else $error("start longer than one cycle");
   chk_start_cs: assert property (erase_start |-> cs_n && $past(cs_n, 2))
      else $error("start before select release");
   chk_busy_len: assert property ($fell(status1[0]) |-> busy_cnt_r == PE_CYCLES)
      else $error("busy length wrong");
   chk_wel_first: assert property ($fell(status1[0]) |-> !$past(status1[1]))
      else $error("wel still set at end");
   chk_dummy_code: assert property ($stable(sr5_cfg) && sr5_cfg[6:4] <= 3'h4
      |=> quad_read_dummy == {$past(sr5_cfg[6:4]), 1'b0} + 5'h2) else $error("dummy wrong");
   chk_dwa_ignored: assert property (quad_read_dwa_dummy == quad_read_dummy)
      else $error("aligned read dummy differs");
   chk_align_sel: assert property ($stable(sr5_cfg) |=> quad_read_aligned == $past(sr5_cfg[0]))
      else $error("align select wrong");
   chk_page_load: assert property ($changed(page_index) |-> erase_start)
      else $error("page index moved");
   chk_fill_one: assert property (erase_fill)
      else $error("fill not one");
endmodule

// >>> bench/qrpe_host_model.sv
// Purpose: host side of the serial link
// Assumes: link clock idles low between frames
// Notes: data line is flipped after a frame as nobody drives it then
`timescale 1ns/1ps
module qrpe_host_model (
   output logic sck,
   output logic cs_n,
   output logic si
);
   initial {sck, cs_n, si} = 3'b010;
   task automatic frame(input logic [31:0] v, input int n);
      cs_n = 1'b0;
      for (int i = 31; i > 31 - n; i--) begin
         si = v[i];
         #400 sck = 1'b1;
         #400 sck = 1'b0;
      end
      #400 cs_n = 1'b1;
      si = ~si;
      #800;
   endtask
endmodule

// >>> bench/qrpe_sequencer_test.sv
// Purpose: directed test of dummy selection and page erase
// Assumes: erase timer shortened to 8 cycles
// Notes: erase start is counted, with page and status captured, on each falling clock edge where it is high
`timescale 1ns/1ps
module qrpe_sequencer_test;
   localparam int PE = 8;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic wrap_mode = 1'b0;
   logic [7:0] sr5_cfg = 8'h00;
   logic [7:0] stat_seen;
   logic [11:0] page_seen;
   wire sck, cs_n, si, quad_read_aligned, erase_start, erase_fill;
   wire [7:0] status1;
   wire [4:0] quad_read_dummy, quad_read_dwa_dummy;
   wire [11:0] page_index;
   int fails = 0, total_checks = 0, starts = 0;
   qrpe_host_model u_qrpe_host_model (.sck(sck), .cs_n(cs_n), .si(si));
   qrpe_sequencer #(.PE_CYCLES(PE)) u_qrpe_sequencer (.clk(clk), .arst_n(arst_n), .sck(sck),
      .cs_n(cs_n), .si(si), .sr5_cfg(sr5_cfg), .wrap_mode(wrap_mode), .status1(status1),
      .quad_read_dummy(quad_read_dummy), .quad_read_dwa_dummy(quad_read_dwa_dummy),
      .quad_read_aligned(quad_read_aligned), .erase_start(erase_start),
      .page_index(page_index), .erase_fill(erase_fill));
   always #50 clk = ~clk;
   always @(negedge clk) if (erase_start === 1'b1) begin
      starts++;
      page_seen = page_index;
      stat_seen = status1;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic erase(input logic [7:0] op, input logic [23:0] a, input int n,
      input logic write_enable_latch, input logic go);
      int s0;
      s0 = starts;
      if (write_enable_latch) u_qrpe_host_model.frame({8'h06, 24'h0}, 8);
      chk("wel", status1, {6'h0, write_enable_latch, 1'b0});
      u_qrpe_host_model.frame({op, a}, n);
      chk("started", starts - s0, go);
      if (go) begin
         chk("page", page_seen, a[19:8]);
         chk("busy", stat_seen, 8'h03);
         for (int i = 0; i < 20 && status1[0] !== 1'b0; i++) @(negedge clk);
         chk("done", status1, 8'h00);
         if (status1[0] !== 1'b0) conclude();
      end
   endtask
   initial begin
      repeat (20) @(negedge clk);
      chk("reset", {status1, quad_read_dummy, erase_fill}, {8'h00, 5'h02, 1'b1});
      arst_n = 1'b1;
      for (int c = 0; c < 16; c++) begin
         sr5_cfg = {1'b0, 3'(c % 8), 3'h0, 1'(c / 8)};
         wrap_mode = c[0];
         repeat (2) @(negedge clk);
         chk("dummy", {quad_read_dummy, quad_read_dwa_dummy, quad_read_aligned},
            {5'((c % 8) > 4 ? 10 : 2 * (c % 8) + 2), 5'((c % 8) > 4 ? 10 : 2 * (c % 8) + 2),
            1'(c / 8)});
      end
      erase(8'h81, 24'hfabcde, 32, 1, 1);
      erase(8'hdb, 24'h0fff00, 32, 1, 1);
      erase(8'h81, 24'h012345, 32, 0, 0);
      erase(8'h20, 24'h012345, 32, 1, 0);
      erase(8'hdb, 24'h0abc00, 24, 1, 0);
      erase(8'h81, 24'h0abc00, 28, 1, 0);
      erase(8'hdb, 24'h055500, 32, 1, 1);
      conclude();
   end
endmodule
bind qrpe_sequencer qrpe_sequencer_sva #(.PE_CYCLES(PE_CYCLES)) u_qrpe_sequencer_sva (
   .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sr5_cfg(sr5_cfg), .status1(status1),
   .quad_read_dummy(quad_read_dummy), .quad_read_dwa_dummy(quad_read_dwa_dummy),
   .quad_read_aligned(quad_read_aligned), .erase_start(erase_start),
   .page_index(page_index), .erase_fill(erase_fill));
